// ===== itu_pkg.sv
// Purpose: Shared constants and types for the I2C target to UART bridge.
// Assumes: One core clock; UART bit time given in core clock cycles.
// Notes:   Error codes keep their enumeration order; unused codes stay reserved.
package itu_pkg;
  localparam int             BYTE_W        = 8;
  localparam int             CNT_W         = 5;
  localparam int             FIFO_DEPTH    = 8;
  localparam int             OBUF_SIZE     = 1;
  localparam logic [4:0]     WBUF_DEPTH    = 5'd16;
  localparam logic [4:0]     OBUF_DEPTH    = 5'd1;
  localparam logic [3:0]     I2C_BITS      = 4'd8;
  localparam logic [7:0]     UNDERRUN_BYTE = 8'hff;
  localparam logic [3:0]     UTX_BITS_PAR  = 4'd11;
  localparam logic [3:0]     UTX_BITS_NOP  = 4'd10;
  localparam logic [3:0]     URX_D_FIRST   = 4'd1;
  localparam logic [3:0]     URX_D_LAST    = 4'd8;
  localparam logic [3:0]     URX_PAR_IDX   = 4'd9;
  localparam logic [3:0]     URX_LAST_PAR  = 4'd10;
  localparam logic [3:0]     URX_LAST_NOP  = 4'd9;
  localparam int             RX_TO_SHIFT   = 5;

  typedef enum logic [7:0] {
    ERR_NONE             = 8'h00,
    ERR_BUF_OVERFLOW     = 8'h01,
    ERR_RX_FULL          = 8'h02,
    ERR_NO_DATA          = 8'h03,
    ERR_I2C_TX_UNDERFLOW = 8'h04,
    ERR_I2C_RX_OVERFLOW  = 8'h05,
    ERR_I2C_ARB_LOST     = 8'h06,
    ERR_I2C_EVT_OVERFLOW = 8'h07,
    ERR_UART_OVERRUN     = 8'h08,
    ERR_UART_BREAK       = 8'h09,
    ERR_UART_PARITY      = 8'h0a,
    ERR_UART_FRAMING     = 8'h0b,
    ERR_UART_RX_TIMEOUT  = 8'h0c
  } itu_err_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WR   = 3'b011,
    ST_WACK = 3'b100,
    ST_RD   = 3'b101,
    ST_RACK = 3'b110
  } itu_i2c_st_t;
endpackage : itu_pkg

// ===== itu_bridge.sv
// Purpose: I2C target that queues written bytes and forwards the first byte of each write to a UART.
// Assumes: SCL, SDA and RXD are asynchronous; baud_div_i is at least 2.
// Notes:   Write bytes pass an 8-word FIFO; a full FIFO makes the target NACK.
`timescale 1ns/1ns

module itu_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          push;
  logic          pop;
  assign in_ready_o  = (cnt != (AW+1)'(D));
  assign out_valid_o = (cnt != '0);
  assign out_data_o  = mem[rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
      if (pop) rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
      if (push && !pop) cnt <= cnt + 1'b1;
      else if (pop && !push) cnt <= cnt - 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (push) mem[wp] <= in_data_i;
  end
endmodule : itu_fifo

module itu_bridge (
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_b_o,
  input  wire logic [6:0]        target_addr_i,
  input  wire logic              uart_rxd_i,
  output logic                   uart_txd_o,
  input  wire logic [15:0]       baud_div_i,
  input  wire logic              parity_en_i,
  input  wire logic              parity_odd_i,
  input  wire logic              uart_rx_new_clr_i,
  output itu_pkg::itu_err_t      latest_error_code_o,
  output logic [7:0]             last_uart_rx_byte_o,
  output logic                   uart_rx_new_flag_o,
  output logic                   uart_send_pending_o,
  output logic                   write_data_seen_o
);
  import itu_pkg::*;

  logic              scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, rxd_m, rxd_s, rxd_d;
  logic              scl_rise, scl_fall, start_cond, stop_cond;
  itu_i2c_st_t       st;
  logic [3:0]        bit_cnt;
  logic [7:0]        shreg;
  logic              rd_mode, drive_low, i2c_hit, fifo_push, stop_ev, txq_take;
  logic              ev_arb, ev_under, ev_nack, ev_evt;
  logic [7:0]        next_tx_byte;
  logic              fifo_in_ready, fifo_out_valid, drain_ready, pop;
  logic [7:0]        fifo_data;
  logic              txq_valid, txq_load;
  logic [7:0]        txq_byte;
  logic [CNT_W-1:0]  tx_byte_count, rx_byte_count, out_len, send_idx;
  logic [7:0]        write_buffer [WBUF_DEPTH];
  logic [7:0]        outgoing_buffer [OBUF_SIZE];
  logic              write_data_seen, stop_pending, stop_do, uart_send_pending, sending;
  logic              utx_busy, utx_start;
  logic [10:0]       utx_shift;
  logic [3:0]        utx_bits;
  logic [15:0]       utx_tmr;
  logic              urx_act, urx_done, urx_fe, urx_par;
  logic [3:0]        urx_idx;
  logic [15:0]       urx_tmr;
  logic [7:0]        urx_data, last_uart_rx_byte;
  logic              uart_rx_new_flag, to_fired, urx_pe, uart_err;
  logic [20:0]       to_cnt;
  itu_err_t          latest_error_code, uart_code;

  // Pins pass three flops; edge and condition logic compares the second and third stages
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {rxd_m, rxd_s, rxd_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
      {rxd_m, rxd_s, rxd_d} <= {uart_rxd_i, rxd_m, rxd_s};
    end
  end
  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

  assign next_tx_byte = txq_valid ? txq_byte : UNDERRUN_BYTE;
  assign sda_o        = 1'b0;
  assign sda_oe_b_o   = ~drive_low;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st        <= ST_IDLE;
      bit_cnt   <= '0;
      shreg     <= '0;
      rd_mode   <= 1'b0;
      drive_low <= 1'b0;
      {i2c_hit, fifo_push, stop_ev, txq_take, ev_arb, ev_under, ev_nack} <= '0;
    end else begin
      {i2c_hit, fifo_push, stop_ev, txq_take, ev_arb, ev_under, ev_nack} <= '0;
      if (start_cond) begin
        st        <= ST_ADDR;
        bit_cnt   <= '0;
        drive_low <= 1'b0;
      end else if (stop_cond) begin
        st        <= ST_IDLE;
        drive_low <= 1'b0;
        stop_ev   <= 1'b1;
      end else begin
        unique case (st)
          ST_IDLE: ;
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 1'b1;
            end else if (scl_fall && bit_cnt == I2C_BITS) begin
              bit_cnt <= '0;
              if (st == ST_ADDR) begin
                if (shreg[7:1] == target_addr_i) begin
                  drive_low <= 1'b1;
                  rd_mode   <= shreg[0];
                  i2c_hit   <= 1'b1;
                  st        <= ST_AACK;
                end else begin
                  st <= ST_IDLE;
                end
              end else begin
                // A full queue is answered with NACK rather than losing a byte
                if (fifo_in_ready) begin
                  fifo_push <= 1'b1;
                  drive_low <= 1'b1;
                end else begin
                  ev_nack <= 1'b1;
                end
                st <= ST_WACK;
              end
            end
          end
          ST_AACK, ST_RACK: begin
            if (st == ST_RACK && scl_rise && sda_s) begin
              st <= ST_IDLE;
            end else if (scl_fall) begin
              if (st == ST_AACK && !rd_mode) begin
                drive_low <= 1'b0;
                st        <= ST_WR;
              end else begin
                shreg     <= next_tx_byte;
                drive_low <= ~next_tx_byte[7];
                txq_take  <= txq_valid;
                ev_under  <= ~txq_valid;
                st        <= ST_RD;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              drive_low <= 1'b0;
              st        <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 1'b1;
              if (!drive_low && !sda_s) begin
                ev_arb    <= 1'b1;
                st        <= ST_IDLE;
              end
            end else if (scl_fall) begin
              if (bit_cnt == I2C_BITS) begin
                drive_low <= 1'b0;
                bit_cnt   <= '0;
                st        <= ST_RACK;
              end else begin
                shreg     <= {shreg[6:0], 1'b0};
                drive_low <= ~shreg[6];
              end
            end
          end
          default: st <= ST_IDLE;
        endcase
      end
    end
  end

  // Drain stalls during a UART send, so a long write can really fill the FIFO
  assign drain_ready = ~uart_send_pending & ~sending & ~i2c_hit;
  assign pop         = fifo_out_valid & drain_ready;
  assign stop_do     = stop_pending & ~fifo_out_valid;

  itu_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_wq (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (fifo_push),
    .in_data_i   (shreg),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (fifo_data)
  );

  assign txq_load = ~i2c_hit & ~txq_valid;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      txq_valid     <= 1'b0;
      txq_byte      <= '0;
      tx_byte_count <= '0;
    end else if (i2c_hit) begin
      txq_valid     <= 1'b0;
      tx_byte_count <= '0;
    end else if (txq_load) begin
      txq_valid <= 1'b1;
      if (tx_byte_count < OBUF_DEPTH) begin
        txq_byte      <= last_uart_rx_byte;
        tx_byte_count <= tx_byte_count + 1'b1;
      end else begin
        txq_byte <= latest_error_code;
      end
    end else if (txq_take) begin
      txq_valid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_byte_count   <= '0;
      write_data_seen <= 1'b0;
    end else if (i2c_hit) begin
      rx_byte_count   <= '0;
      write_data_seen <= 1'b0;
    end else if (pop) begin
      write_data_seen <= 1'b1;
      if (rx_byte_count < WBUF_DEPTH) rx_byte_count <= rx_byte_count + 1'b1;
    end else if (stop_do) begin
      write_data_seen <= 1'b0;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (pop && rx_byte_count < WBUF_DEPTH) write_buffer[rx_byte_count[3:0]] <= fifo_data;
  end

  // The stop waits until every queued write byte has been drained
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stop_pending       <= 1'b0;
      out_len            <= '0;
      outgoing_buffer[0] <= '0;
    end else begin
      if (stop_ev) stop_pending <= 1'b1;
      else if (stop_do) stop_pending <= 1'b0;
      if (stop_do && write_data_seen) begin
        outgoing_buffer[0] <= write_buffer[0];
        out_len <= (rx_byte_count > OBUF_DEPTH) ? OBUF_DEPTH : rx_byte_count;
      end
    end
  end
  assign ev_evt = (stop_ev | i2c_hit) & stop_pending;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      uart_send_pending <= 1'b0;
      sending           <= 1'b0;
      send_idx          <= '0;
      utx_start         <= 1'b0;
    end else begin
      utx_start <= 1'b0;
      if (stop_do && write_data_seen) uart_send_pending <= 1'b1;
      else if (!sending) uart_send_pending <= 1'b0;
      if (!sending) begin
        sending  <= uart_send_pending;
        send_idx <= '0;
      end else if (!utx_busy && !utx_start) begin
        if (send_idx < out_len) begin
          utx_start <= 1'b1;
          send_idx  <= send_idx + 1'b1;
        end else begin
          sending <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      utx_busy  <= 1'b0;
      utx_shift <= '1;
      utx_bits  <= '0;
      utx_tmr   <= '0;
    end else if (utx_start) begin
      utx_busy  <= 1'b1;
      utx_tmr   <= baud_div_i - 16'd1;
      utx_bits  <= parity_en_i ? UTX_BITS_PAR : UTX_BITS_NOP;
      utx_shift <= {1'b1, parity_en_i ? ^outgoing_buffer[0] ^ parity_odd_i : 1'b1,
                    outgoing_buffer[0], 1'b0};
    end else if (utx_busy) begin
      if (utx_tmr == '0) begin
        utx_tmr   <= baud_div_i - 16'd1;
        utx_shift <= {1'b1, utx_shift[10:1]};
        utx_bits  <= utx_bits - 1'b1;
        if (utx_bits == 4'd1) utx_busy <= 1'b0;
      end else begin
        utx_tmr <= utx_tmr - 1'b1;
      end
    end
  end
  assign uart_txd_o = utx_shift[0];

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      urx_act  <= 1'b0;
      urx_done <= 1'b0;
      urx_fe   <= 1'b0;
      urx_par  <= 1'b0;
      urx_idx  <= '0;
      urx_tmr  <= '0;
      urx_data <= '0;
    end else begin
      urx_done <= 1'b0;
      if (!urx_act) begin
        if (rxd_d && !rxd_s) begin
          urx_act <= 1'b1;
          urx_idx <= '0;
          urx_tmr <= baud_div_i >> 1;
        end
      end else if (urx_tmr != '0) begin
        urx_tmr <= urx_tmr - 1'b1;
      end else begin
        urx_tmr <= baud_div_i - 16'd1;
        urx_idx <= urx_idx + 1'b1;
        if (urx_idx == '0 && rxd_s) urx_act <= 1'b0;
        if (urx_idx >= URX_D_FIRST && urx_idx <= URX_D_LAST) urx_data <= {rxd_s, urx_data[7:1]};
        if (urx_idx == URX_PAR_IDX && parity_en_i) urx_par <= rxd_s;
        if (urx_idx == (parity_en_i ? URX_LAST_PAR : URX_LAST_NOP)) begin
          urx_act  <= 1'b0;
          urx_done <= 1'b1;
          urx_fe   <= ~rxd_s;
        end
      end
    end
  end

  // Timeout: unread byte and an idle line for 32 bit times, reported once
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_uart_rx_byte <= '0;
      uart_rx_new_flag  <= 1'b0;
      to_cnt            <= '0;
      to_fired          <= 1'b0;
    end else begin
      if (urx_done) begin
        last_uart_rx_byte <= urx_data;
        uart_rx_new_flag  <= 1'b1;
      end else if (uart_rx_new_clr_i) begin
        uart_rx_new_flag <= 1'b0;
      end
      if (urx_done || !uart_rx_new_flag || urx_act) begin
        to_cnt   <= '0;
        to_fired <= 1'b0;
      end else if (to_cnt != (21'(baud_div_i) << RX_TO_SHIFT)) begin
        to_cnt <= to_cnt + 1'b1;
      end else begin
        to_fired <= 1'b1;
      end
    end
  end

  assign urx_pe = parity_en_i & (urx_par != (^urx_data ^ parity_odd_i));
  always_comb begin
    uart_err  = 1'b1;
    uart_code = ERR_NONE;
    if (urx_done && urx_fe && urx_data == '0 && !urx_par) uart_code = ERR_UART_BREAK;
    else if (urx_done && urx_fe) uart_code = ERR_UART_FRAMING;
    else if (urx_done && urx_pe) uart_code = ERR_UART_PARITY;
    else if (urx_done && uart_rx_new_flag) uart_code = ERR_UART_OVERRUN;
    else if (!to_fired && to_cnt == (21'(baud_div_i) << RX_TO_SHIFT) && !urx_act
             && uart_rx_new_flag && !urx_done) uart_code = ERR_UART_RX_TIMEOUT;
    else uart_err = 1'b0;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) latest_error_code <= ERR_NONE;
    else if (ev_arb) latest_error_code <= ERR_I2C_ARB_LOST;
    else if (ev_under) latest_error_code <= ERR_I2C_TX_UNDERFLOW;
    else if (ev_nack) latest_error_code <= ERR_I2C_RX_OVERFLOW;
    else if (ev_evt) latest_error_code <= ERR_I2C_EVT_OVERFLOW;
    else if (uart_err) latest_error_code <= uart_code;
  end

  assign latest_error_code_o = latest_error_code;
  assign last_uart_rx_byte_o = last_uart_rx_byte;
  assign uart_rx_new_flag_o  = uart_rx_new_flag;
  assign uart_send_pending_o = uart_send_pending;
  assign write_data_seen_o   = write_data_seen;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_stop_data;
    stop_do && write_data_seen;
  endsequence
  sequence s_armed;
    uart_send_pending && !write_data_seen && outgoing_buffer[0] == $past(write_buffer[0]);
  endsequence
  chk_start_clear: assert property (i2c_hit |=> rx_byte_count == '0 && tx_byte_count == '0 && !write_data_seen) else $error("start did not clear");
  chk_txq_flush: assert property (i2c_hit |=> !txq_valid ##1 (txq_valid && tx_byte_count == 5'd1)) else $error("read queue not reloaded");
  chk_drain_store: assert property (pop && rx_byte_count < WBUF_DEPTH |=> write_data_seen && rx_byte_count == $past(rx_byte_count) + 5'd1) else $error("drained byte not counted");
  chk_drain_drop: assert property (pop && rx_byte_count == WBUF_DEPTH |=> rx_byte_count == WBUF_DEPTH) else $error("full buffer grew");
  chk_first_byte: assert property (txq_load && tx_byte_count == '0 |=> txq_byte == $past(last_uart_rx_byte) && tx_byte_count == 5'd1) else $error("first read byte wrong");
  chk_err_fill: assert property (txq_load && tx_byte_count != '0 |=> txq_byte == $past(latest_error_code)) else $error("error fill wrong");
  chk_stop_copy: assert property (s_stop_data |=> s_armed) else $error("stop copy missing");
  chk_no_send: assert property (stop_do && !write_data_seen && !uart_send_pending |=> !uart_send_pending) else $error("send without data");
  chk_arb_code: assert property (ev_arb |=> latest_error_code == ERR_I2C_ARB_LOST) else $error("arbitration code missing");
  chk_uart_store: assert property (urx_done |=> last_uart_rx_byte == $past(urx_data) && uart_rx_new_flag) else $error("uart byte not stored");
  chk_uart_err: assert property (uart_err && !(ev_arb || ev_under || ev_nack || ev_evt) |=> latest_error_code == $past(uart_code)) else $error("uart error lost");
  chk_send_start: assert property (uart_send_pending && !sending && !stop_do |=> !uart_send_pending ##[1:3] !uart_txd_o) else $error("send did not start");
endmodule : itu_bridge

// ===== itu_uart_dev.sv
// Purpose: Behavioural UART device on the far side of the bridge.
// Assumes: Even parity is enabled; 400 ns per bit on both lines.
// Notes:   par_bad_i flips the parity bit so the bridge sees a parity fault.
`timescale 1ns/1ns
module itu_uart_dev #(
  parameter int BIT_NS = 400
) (
  input  wire logic       send_i,
  input  wire logic [7:0] data_i,
  input  wire logic       par_bad_i,
  input  wire logic       txd_i,
  output logic            rxd_o,
  output logic [7:0]      got_o,
  output int              frames_o
);
  initial begin
    rxd_o    = 1'b1;
    got_o    = 8'h00;
    frames_o = 0;
  end
  // One frame per rising send_i: start, data LSB first, parity, stop
  always @(posedge send_i) begin : tx_frame
    rxd_o = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      rxd_o = data_i[i];
      #BIT_NS;
    end
    rxd_o = ^data_i ^ par_bad_i;
    #BIT_NS;
    rxd_o = 1'b1;
    #BIT_NS;
  end
  // Sample mid-bit; the wait past parity lands in the stop bit
  always @(negedge txd_i) begin : rx_frame
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #BIT_NS;
      got_o[i] = txd_i;
    end
    #(2 * BIT_NS);
    frames_o++;
  end
endmodule : itu_uart_dev

// ===== tb.sv
// Purpose: Self-checking bench for the I2C target to UART bridge.
// Assumes: The bench is the I2C controller; baud_div 8 gives a 400 ns bit.
// Notes:   Inputs change on falling core clock edges.
`timescale 1ns/1ns
module tb;
  import itu_pkg::*;
  // Half SCL period; 8 core cycles make the 400 ns link clock
  localparam int         H    = 4;
  localparam logic [6:0] ADDR = 7'h2a;
  logic       core_clk_i = 1'b0;
  logic       rst_b_i    = 1'b0;
  logic       scl        = 1'b1;
  logic       sda_m      = 1'b1;
  logic       clr        = 1'b0;
  logic       dev_go     = 1'b0;
  logic       odd        = 1'b0;
  logic       dev_bad    = 1'b0;
  logic [7:0] dev_byte   = 8'h00;
  wire        sda_o, sda_oe_b, txd, rxd, newf, pend, wseen;
  wire  [7:0] lrx, dev_got;
  itu_err_t   err;
  int         dev_frames, n, n0, failures = 0, checks_done = 0, seed = 45;
  logic [7:0] a, b, d, d0, q;
  logic       ack;
  // Open-drain wire: controller and target can only pull low
  wire        sda_w = sda_m & (sda_oe_b | sda_o);
  itu_bridge dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_b_o(sda_oe_b), .target_addr_i(ADDR), .uart_rxd_i(rxd),
    .uart_txd_o(txd), .baud_div_i(16'h0008), .parity_en_i(1'b1), .parity_odd_i(odd),
    .uart_rx_new_clr_i(clr), .latest_error_code_o(err), .last_uart_rx_byte_o(lrx),
    .uart_rx_new_flag_o(newf), .uart_send_pending_o(pend), .write_data_seen_o(wseen));
  itu_uart_dev dev_u (.send_i(dev_go), .data_i(dev_byte), .par_bad_i(dev_bad),
    .txd_i(txd), .rxd_o(rxd), .got_o(dev_got), .frames_o(dev_frames));
  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      failures++;
      results();
    end
  endtask : tmo
  function automatic logic [7:0] exp_rd(input int idx, input logic [7:0] last,
                                        input itu_err_t code);
    return (idx == 0) ? last : code;
  endfunction : exp_rd
  task automatic uart_send(input logic [7:0] v, input logic bad);
    dev_byte = v;
    dev_bad  = bad;
    dev_go   = 1'b1;
    cyc(1);
    dev_go = 1'b0;
    for (n = 0; n < 300 && lrx !== v; n++) cyc(1);
    tmo(lrx === v);
    cyc(1);
  endtask : uart_send
  task automatic i2c_start;
    sda_m = 1'b0;
    cyc(H);
    scl = 1'b0;
    cyc(2);
  endtask : i2c_start
  task automatic i2c_stop;
    sda_m = 1'b0;
    cyc(H);
    scl = 1'b1;
    cyc(H);
    sda_m = 1'b1;
  endtask : i2c_stop
  // Nine clocks: eight data bits MSB first, then the acknowledge slot
  task automatic i2c_byte(input logic [7:0] dv, input logic mack, output logic [7:0] r,
                          output logic ak);
    for (int i = 8; i >= 0; i--) begin
      sda_m = (i == 0) ? mack : dv[i-1];
      cyc(H - 2);
      scl = 1'b1;
      cyc(H);
      if (i > 0) r[i-1] = sda_w;
      else ak = sda_w;
      scl = 1'b0;
      cyc(2);
    end
  endtask : i2c_byte
  initial begin
    #2000000;
    failures++;
    results();
  end
  initial begin
    cyc(5);
    rst_b_i = 1'b1;
    cyc(6);
    chk("error code", ERR_NONE, err);
    chk("txd idle", 8'h01, {7'h00, txd});
    a = 8'($random(seed)) | 8'h01;
    b = a ^ (8'($random(seed)) | 8'h01);
    uart_send(a, 1'b1);
    chk("rx byte", a, lrx);
    chk("rx flag", 8'h01, {7'h00, newf});
    chk("parity code", ERR_UART_PARITY, err);
    uart_send(b, 1'b0);
    chk("rx byte", b, lrx);
    chk("overrun code", ERR_UART_OVERRUN, err);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
    chk("rx flag", 8'h00, {7'h00, newf});
    n0 = dev_frames;
    i2c_start();
    i2c_byte({ADDR, 1'b1}, 1'b1, q, ack);
    chk("addr ack", 8'h00, {7'h00, ack});
    i2c_byte(8'hff, 1'b0, q, ack);
    chk("read byte0", exp_rd(0, b, ERR_UART_OVERRUN), q);
    i2c_byte(8'hff, 1'b1, q, ack);
    chk("read byte1", exp_rd(1, b, ERR_UART_OVERRUN), q);
    i2c_stop();
    cyc(200);
    chk("frames after read", 8'(n0), 8'(dev_frames));
    // More bytes than the write buffer holds; the excess drops silently
    i2c_start();
    i2c_byte({ADDR, 1'b0}, 1'b1, q, ack);
    for (int i = 0; i < 18; i++) begin
      d = 8'($random(seed));
      if (i == 0) d0 = d;
      i2c_byte(d, 1'b1, q, ack);
      chk("write ack", 8'h00, {7'h00, ack});
    end
    cyc(2);
    chk("write seen", 8'h01, {7'h00, wseen});
    i2c_stop();
    for (n = 0; n < 50 && pend !== 1'b1 && dev_frames == n0; n++) cyc(1);
    tmo(pend === 1'b1);
    chk("write seen", 8'h00, {7'h00, wseen});
    for (n = 0; n < 400 && dev_frames == n0; n++) cyc(1);
    tmo(dev_frames != n0);
    chk("uart tx byte", d0, dev_got);
    chk("error code", ERR_UART_OVERRUN, err);
    cyc(200);
    chk("frames after write", 8'(n0 + 1), 8'(dev_frames));
    // Odd parity: a frame with flipped even parity is now well formed
    odd = 1'b1;
    d = b ^ (8'($random(seed)) | 8'h01);
    uart_send(d, 1'b1);
    chk("odd rx byte", d, lrx);
    chk("odd parity code", ERR_UART_OVERRUN, err);
    cyc(300);
    chk("timeout code", ERR_UART_RX_TIMEOUT, err);
    results();
  end
endmodule : tb
